// *** dv/mbs_exec_assertions.sv ***
// Purpose: Port checker for the multiply, branch and skip executor.
// Assumes: An instruction is taken when issue_in and ready_out are high together.
// Notes:   Expected values are worked out from the operands seen at the taking edge.
`timescale 1ns/1ps
`default_nettype none
module mbs_exec_assertions
	import mbs_pkg::*;
(
	input wire logic             core_clk_in,
	input wire logic             rst_b_in,
	input wire logic             issue_in,
	input wire logic [15:0]      instr_in,
	input wire logic [15:0]      instr_word2_in,
	input wire logic             next_is_long_in,
	input wire logic [PC_W-1:0]  pc_in,
	input wire logic [7:0]       rd_val_in,
	input wire logic [7:0]       rr_val_in,
	input wire logic [7:0]       io_val_in,
	input wire logic [15:0]      z_ptr_in,
	input wire logic [STK_W-1:0] stack_top_in,
	input wire logic [7:0]       flags_in,
	input wire logic             ready_out,
	input wire logic             flags_we_out,
	input wire logic [7:0]       flags_out,
	input wire mbs_pair_wr_t     pair_wr_out,
	input wire mbs_flow_t        flow_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic go;
	assign go = issue_in && ready_out;
	a_mul_int_product: assert property (go && (instr_in & M_MUL) == P_MUL |=>
		pair_wr_out.we && flags_we_out && !ready_out && pair_wr_out.data ==
		{8'h00, $past(rd_val_in)} * {8'h00, $past(rr_val_in)} ##1 ready_out)
		else $error("unsigned product or its timing is wrong");
	a_frac_shifted: assert property (go && (instr_in & M_MSU) == P_FRACTIONAL_UNSIGNED_PRODUCT |=>
		pair_wr_out.data == ({8'h00, $past(rd_val_in)} * {8'h00, $past(rr_val_in)}) << 1)
		else $error("fractional product is not shifted left by one");
	a_jump_direct: assert property (go && (instr_in & M_LONG) == P_JMP |=>
		flow_out.pc_load && flow_out.pc_next == $past(instr_word2_in) ##1 !ready_out ##1 ready_out)
		else $error("direct jump target or length is wrong");
	a_jump_indirect: assert property (go && instr_in == P_IJ |=>
		flow_out.pc_load && flow_out.pc_next == $past(z_ptr_in) && !flags_we_out)
		else $error("indirect jump does not follow the pointer");
	a_irq_exit: assert property (go && instr_in == P_INTERRUPT_EXIT |=>
		flags_we_out && flags_out[FL_I] && flow_out.pop ##1 !ready_out[*2] ##1 ready_out)
		else $error("interrupt exit flags or length are wrong");
	a_cmp_zero: assert property (go && (instr_in & M_TWO) == P_CP |=>
		flags_we_out && ready_out && flags_out[FL_Z] == ($past(rd_val_in) == $past(rr_val_in)))
		else $error("register compare zero flag is wrong");
	a_equal_branch: assert property (go && (instr_in & 16'hfc07) == 16'hf001 |=>
		flow_out.pc_load == $past(flags_in[FL_Z]))
		else $error("equal branch decision is wrong");
	a_signed_less: assert property (go && (instr_in & 16'hfc07) == 16'hf004 |=>
		flow_out.pc_load == ($past(flags_in[FL_N]) ^ $past(flags_in[FL_V])))
		else $error("signed less branch decision is wrong");
	a_skip_long: assert property (go && (instr_in & M_TWO) == P_COMPARE_SKIP_EQUAL && next_is_long_in &&
		rd_val_in == rr_val_in |=> flow_out.pc_load && !ready_out &&
		flow_out.pc_next == $past(pc_in) + PC_THREE ##1 !ready_out ##1 ready_out)
		else $error("skip over a two-word instruction is wrong");
	a_io_skip: assert property (go && (instr_in & M_IOB) == P_SKIP_IO_BIT_SET |=>
		flow_out.pc_load == $past(io_val_in[instr_in[2:0]]))
		else $error("I/O bit skip decision is wrong");
	a_hold_quiet: assert property (!ready_out |=>
		!flow_out.pc_load && !pair_wr_out.we && !flags_we_out)
		else $error("result pulse while an instruction is still running");
endmodule // mbs_exec_assertions
bind mbs_exec mbs_exec_assertions u_chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.issue_in(issue_in), .instr_in(instr_in), .instr_word2_in(instr_word2_in),
	.next_is_long_in(next_is_long_in), .pc_in(pc_in), .rd_val_in(rd_val_in),
	.rr_val_in(rr_val_in), .io_val_in(io_val_in), .z_ptr_in(z_ptr_in),
	.stack_top_in(stack_top_in), .flags_in(flags_in), .ready_out(ready_out),
	.flags_we_out(flags_we_out), .flags_out(flags_out), .pair_wr_out(pair_wr_out),
	.flow_out(flow_out));
`default_nettype wire

// *** dv/mbs_prog_mem.sv ***
// Purpose: Program memory model feeding instruction words by address.
// Assumes: The bench loads words into mem_q before issuing them.
// Notes:   Unloaded words read as zero, a one-word instruction.
`timescale 1ns/1ps
`default_nettype none
module mbs_prog_mem
	import mbs_pkg::*;
(
	input  wire logic [PC_W-1:0] pc_in,
	output logic      [15:0]     instr_out,
	output logic      [15:0]     word2_out,
	output logic                 next_long_out
);
	logic [15:0] mem_q [0:255];
	initial for (int i = 0; i < 256; i++) mem_q[i] = 16'h0000;
	assign instr_out = mem_q[pc_in[7:0]];
	assign word2_out = mem_q[pc_in[7:0] + 8'h01];
	// The follower decides the skip distance, so it is decoded here and not by the bench.
	assign next_long_out = ((word2_out & M_LONG) == P_JMP) || ((word2_out & M_LONG) == P_CALL);
endmodule // mbs_prog_mem
`default_nettype wire

// *** dv/test_mul_branch_skip_exec.sv ***
// Purpose: Self-checking bench for the executor.
// Assumes: One instruction in flight; the next is offered after ready_out returns.
// Notes:   Operands also feed the pointer and stack inputs as {a,b} and {b,a}.
`timescale 1ns/1ps
`default_nettype none
module test_mul_branch_skip_exec
	import mbs_pkg::*;
;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic issue_in = 1'b0;
	logic [15:0] pc_in = 16'h0000, z_ptr_in = 16'h0000, stack_top_in = 16'h0000, instr, word2;
	logic [7:0] rd_val_in = 8'h00, rr_val_in = 8'h00, io_val_in = 8'h00, flags_in = 8'h00;
	logic next_long, ready_out, flags_we_out;
	logic [7:0] flags_out;
	mbs_pair_wr_t pair_wr_out;
	mbs_flow_t flow_out;
	int bad_count = 0;
	int tests_run = 0;
	always #2 core_clk_in = ~core_clk_in;
	mbs_prog_mem pm (.pc_in(pc_in), .instr_out(instr), .word2_out(word2), .next_long_out(next_long));
	mbs_exec dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .issue_in(issue_in),
		.instr_in(instr), .instr_word2_in(word2), .next_is_long_in(next_long), .pc_in(pc_in),
		.rd_val_in(rd_val_in), .rr_val_in(rr_val_in), .io_val_in(io_val_in), .z_ptr_in(z_ptr_in),
		.stack_top_in(stack_top_in), .flags_in(flags_in), .ready_out(ready_out),
		.flags_we_out(flags_we_out), .flags_out(flags_out), .pair_wr_out(pair_wr_out),
		.flow_out(flow_out));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Places op at pc and returns one ns after the taking edge, while the results stand.
	task automatic run(input logic [15:0] pc, op, input logic [7:0] a, b, fl);
		pm.mem_q[pc[7:0]] = op;
		@(posedge core_clk_in);
		{pc_in, rd_val_in, rr_val_in, io_val_in} <= {pc, a, b, b};
		{z_ptr_in, stack_top_in, flags_in, issue_in} <= {a, b, b, a, fl, 1'b1};
		@(posedge core_clk_in);
		issue_in <= 1'b0;
		#1;
	endtask
	task automatic idle(input int n);
		int c;
		c = 0;
		while (ready_out !== 1'b1 && c < 8) begin
			@(posedge core_clk_in);
			#1;
			c++;
		end
		chk(32'(c), 32'(n));
	endtask
	task automatic t_mul();
		run(16'h0001, P_MUL, 8'hff, 8'hff, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'hfe01, 2'b01});
		idle(1);
		run(16'h0002, P_SIGNED_PRODUCT_OP, 8'h00, 8'h45, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'h0000, 2'b10});
		idle(1);
		run(16'h0003, P_MSU, 8'hff, 8'h02, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'hfffe, 2'b01});
		idle(1);
		run(16'h0004, P_FRACTIONAL_UNSIGNED_PRODUCT, 8'h80, 8'hc0, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'hc000, 2'b00});
		idle(1);
		run(16'h0005, P_SIGNED_PRODUCT_OP, 8'hff, 8'hff, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'h0001, 2'b00});
		idle(1);
		run(16'h0006, P_FRACTIONAL_SIGNED_PRODUCT, 8'hc0, 8'hc0, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'h2000, 2'b00});
		idle(1);
		run(16'h0007, P_FMSU, 8'h80, 8'h02, 8'h00);
		chk({pair_wr_out, flags_out[1:0]}, {1'b1, 16'hfe00, 2'b01});
		idle(1);
		$display("Multiply test done");
	endtask
	task automatic t_flow();
		run(16'h0010, 16'hcffd, 8'h00, 8'h00, 8'h00);
		chk({flow_out.pc_load, flow_out.pc_next, flags_we_out}, {1'b1, 16'h000e, 1'b0});
		idle(1);
		run(16'h0011, P_IJ, 8'h12, 8'h34, 8'h00);
		chk({flow_out.pc_load, flow_out.pc_next, flags_we_out}, {1'b1, 16'h1234, 1'b0});
		idle(1);
		pm.mem_q[8'h13] = 16'h0abc;
		run(16'h0012, P_JMP, 8'h00, 8'h00, 8'h00);
		chk({flow_out.pc_load, flow_out.pc_next}, {1'b1, 16'h0abc});
		idle(2);
		pm.mem_q[8'h15] = 16'h0abc;
		run(16'h0014, P_CALL, 8'h00, 8'h00, 8'h00);
		chk({flow_out.pc_next, flow_out.push, flow_out.push_data}, {16'h0abc, 1'b1, 16'h0016});
		idle(3);
		run(16'h0016, 16'hd004, 8'h00, 8'h00, 8'h00);
		chk({flow_out.pc_next, flow_out.push, flow_out.push_data}, {16'h001b, 1'b1, 16'h0017});
		idle(2);
		run(16'h0017, P_INTERRUPT_EXIT, 8'h00, 8'h00, 8'h00);
		chk({flow_out.pop, flags_we_out, flags_out}, {1'b1, 1'b1, 8'h80});
		idle(3);
		run(16'h0018, P_RET, 8'h12, 8'h34, 8'h00);
		chk({flow_out.pop, flags_we_out, flow_out.pc_next}, {1'b1, 1'b0, 16'h3412});
		idle(3);
		run(16'h0019, P_IC, 8'h12, 8'h34, 8'h00);
		chk({flow_out.pc_next, flow_out.push, flow_out.push_data}, {16'h1234, 1'b1, 16'h001a});
		idle(2);
		$display("Jump and call test done");
	endtask
	task automatic cmp_one(input logic [15:0] op, input logic [7:0] a, b, fl, exp);
		run(16'h0020, op, a, b, fl);
		chk({flags_we_out, flags_out & 8'h2f, flow_out.pc_load}, {1'b1, exp, 1'b0});
		idle(0);
	endtask
	task automatic skip_one(input logic [15:0] pc, op, input logic [7:0] v, input logic tk, long);
		pm.mem_q[pc[7:0] + 8'h01] = long ? P_JMP : 16'h0000;
		run(pc, op, v, v, 8'h00);
		chk({flow_out.pc_load, flow_out.pc_next}, {tk, tk ? pc + 16'(2 + long) : 16'h0});
		idle(tk ? 1 + long : 0);
	endtask
	task automatic br_one(input logic [15:0] op, input logic [7:0] fl, input logic tk);
		run(16'h0050, op, 8'h00, 8'h00, fl);
		chk({flow_out.pc_load, flow_out.pc_next, flags_we_out}, {tk, tk ? 16'h0053 : 16'h0, 1'b0});
		idle(tk ? 1 : 0);
	endtask
	task automatic t_decide();
		cmp_one(P_CP, 8'h10, 8'h20, 8'h00, 8'h05);
		cmp_one(P_CPC, 8'h05, 8'h05, 8'h03, 8'h25);
		cmp_one(16'h370f, 8'h80, 8'h00, 8'h00, 8'h28);
		skip_one(16'h0030, P_COMPARE_SKIP_EQUAL, 8'h55, 1'b1, 1'b1);
		skip_one(16'h0034, P_COMPARE_SKIP_EQUAL | 16'h0001, 8'h55, 1'b1, 1'b0);
		skip_one(16'h0040, P_SKIP_REG_BIT_SET | 16'h0007, 8'h80, 1'b1, 1'b0);
		skip_one(16'h0042, P_SKIP_REG_BIT_CLEAR | 16'h0007, 8'h80, 1'b0, 1'b0);
		skip_one(16'h0044, P_SKIP_IO_BIT_CLEAR, 8'h01, 1'b0, 1'b0);
		skip_one(16'h0046, P_SKIP_IO_BIT_SET, 8'h01, 1'b1, 1'b1);
		for (int s = 0; s < 8; s++) begin
			// At s = 4 the flags keep S equal to N xor V, as a running core holds them.
			br_one(16'hf010 | 16'(s), (s == FL_S) ? 8'h14 : 8'h01 << s, 1'b1);
			br_one(16'hf410 | 16'(s), (s == FL_S) ? 8'h14 : 8'h01 << s, 1'b0);
			br_one(16'hf410 | 16'(s), 8'h00, 1'b1);
		end
		br_one(16'hf014, 8'h0c, 1'b0);
		br_one(16'hf414, 8'h0c, 1'b1);
		br_one(16'hf014, 8'h14, 1'b1);
		$display("Compare, skip and branch test done");
	endtask
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		#1;
		chk({ready_out, flags_we_out, pair_wr_out.we, flow_out.pc_load}, 32'h0);
		@(posedge core_clk_in);
		#1;
		chk(ready_out, 1'b1);
		t_mul();
		t_flow();
		t_decide();
		stop_test();
	end
endmodule // test_mul_branch_skip_exec
`default_nettype wire

// *** hw/mbs_exec.sv ***
// Purpose: Executes multiplies, jumps, calls, returns, compares, skips and branches.
// Assumes: Operand values are read by the core from the register file and I/O space.
// Notes:   One instruction is taken when issue_in and ready_out are both high.
`timescale 1ns/1ps
`default_nettype none
module mbs_exec
	import mbs_pkg::*;
(
	input  wire logic             core_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             issue_in,
	input  wire logic [15:0]      instr_in,
	input  wire logic [15:0]      instr_word2_in,
	input  wire logic             next_is_long_in,
	input  wire logic [PC_W-1:0]  pc_in,
	input  wire logic [7:0]       rd_val_in,
	input  wire logic [7:0]       rr_val_in,
	input  wire logic [7:0]       io_val_in,
	input  wire logic [15:0]      z_ptr_in,
	input  wire logic [STK_W-1:0] stack_top_in,
	input  wire logic [7:0]       flags_in,
	output logic                  ready_out,
	output logic                  flags_we_out,
	output logic      [7:0]       flags_out,
	output mbs_pair_wr_t          pair_wr_out,
	output mbs_flow_t             flow_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers.
	function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] p);
		hit = (w & m) == p;
	endfunction

	function automatic logic is_long(input logic [15:0] w);
		is_long = hit(w, M_LONG, P_JMP) | hit(w, M_LONG, P_CALL) | hit(w, M_LDS, P_LDS);
	endfunction

	logic [2:0]  busy_q;
	logic [2:0]  busy_d;
	logic        a_s;
	logic        b_s;
	logic        frac;
	logic        is_mul;
	logic [15:0] prod;
	logic        prod_c;
	logic [7:0]  cmp_b;
	logic        cmp_cin;
	logic        is_cmp;
	logic [8:0]  diff;
	logic        cond;
	logic        is_br;
	logic        is_skip;
	logic [15:0] rel12;
	logic [15:0] rel7;
	logic [2:0]  bsel;
	// Cycle count of the instruction on offer, before the N-1 adjustment.
	logic [2:0]  cyc;

	////////////////////////////////////////////////////////////////////////////////
	// Multiply.
	always_comb begin
		is_mul = hit(instr_in, M_MUL, P_MUL) | hit(instr_in, M_SIGNED_PRODUCT_OP, P_SIGNED_PRODUCT_OP)
			| hit(instr_in, M_MSU, P_MSU) | hit(instr_in, M_MSU, P_FRACTIONAL_UNSIGNED_PRODUCT)
			| hit(instr_in, M_MSU, P_FRACTIONAL_SIGNED_PRODUCT) | hit(instr_in, M_MSU, P_FMSU);
		a_s  = hit(instr_in, M_SIGNED_PRODUCT_OP, P_SIGNED_PRODUCT_OP) | hit(instr_in, M_MSU, P_MSU)
			| hit(instr_in, M_MSU, P_FRACTIONAL_SIGNED_PRODUCT) | hit(instr_in, M_MSU, P_FMSU);
		b_s  = hit(instr_in, M_SIGNED_PRODUCT_OP, P_SIGNED_PRODUCT_OP) | hit(instr_in, M_MSU, P_FRACTIONAL_SIGNED_PRODUCT);
		frac = hit(instr_in, M_MSU, P_FRACTIONAL_UNSIGNED_PRODUCT) | hit(instr_in, M_MSU, P_FRACTIONAL_SIGNED_PRODUCT)
			| hit(instr_in, M_MSU, P_FMSU);
	end

	mbs_multiplier u_mul (
		.a_in        (rd_val_in),
		.b_in        (rr_val_in),
		.a_signed_in (a_s),
		.b_signed_in (b_s),
		.frac_in     (frac),
		.prod_out    (prod),
		.carry_out   (prod_c)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Compare and condition evaluation.
	always_comb begin
		is_cmp  = hit(instr_in, M_TWO, P_CP) | hit(instr_in, M_TWO, P_CPC)
			| hit(instr_in, M_REL, P_CPI);
		cmp_b   = hit(instr_in, M_REL, P_CPI) ? {instr_in[11:8], instr_in[3:0]} : rr_val_in;
		cmp_cin = hit(instr_in, M_TWO, P_CPC) & flags_in[FL_C];
		diff    = {1'b0, rd_val_in} - {1'b0, cmp_b} - {8'h00, cmp_cin};
		bsel    = instr_in[2:0];
		is_br   = hit(instr_in, M_BR, P_BRS) | hit(instr_in, M_BR, P_BRC);
		// Named and signed branches are encodings of the generic pair with s fixed.
		cond    = flags_in[bsel] ^ instr_in[10];
		if (bsel == 3'(FL_S)) begin
			cond = (flags_in[FL_N] ^ flags_in[FL_V]) ^ instr_in[10];
		end
		is_skip = 1'b1;
		if (hit(instr_in, M_TWO, P_COMPARE_SKIP_EQUAL)) begin
			cond = rd_val_in == rr_val_in;
		end else if (hit(instr_in, M_SKB, P_SKIP_REG_BIT_CLEAR) | hit(instr_in, M_SKB, P_SKIP_REG_BIT_SET)) begin
			cond = rr_val_in[bsel] == instr_in[9];
		end else if (hit(instr_in, M_IOB, P_SKIP_IO_BIT_CLEAR) | hit(instr_in, M_IOB, P_SKIP_IO_BIT_SET)) begin
			cond = io_val_in[bsel] == instr_in[9];
		end else begin
			is_skip = 1'b0;
		end
		rel12 = {{4{instr_in[11]}}, instr_in[11:0]};
		rel7  = {{9{instr_in[9]}}, instr_in[9:3]};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Cycle count of the instruction on offer.
	// Not-taken skips and branches cost one cycle; the core then steps the PC itself.
	always_comb begin
		cyc = CYC_ONE;
		if (is_mul) begin
			cyc = CYC_TWO;
		end else if (is_cmp) begin
			cyc = CYC_ONE;
		end else if (hit(instr_in, M_REL, P_RJ) | hit(instr_in, M_REL, P_RC)) begin
			cyc = hit(instr_in, M_REL, P_RC) ? CYC_THREE : CYC_TWO;
		end else if (hit(instr_in, M_FULL, P_IJ) | hit(instr_in, M_FULL, P_IC)) begin
			cyc = hit(instr_in, M_FULL, P_IC) ? CYC_THREE : CYC_TWO;
		end else if (hit(instr_in, M_LONG, P_JMP) | hit(instr_in, M_LONG, P_CALL)) begin
			cyc = hit(instr_in, M_LONG, P_CALL) ? CYC_FOUR : CYC_THREE;
		end else if (hit(instr_in, M_FULL, P_RET) | hit(instr_in, M_FULL, P_INTERRUPT_EXIT)) begin
			cyc = CYC_FOUR;
		end else if (is_skip && cond) begin
			cyc = next_is_long_in ? CYC_THREE : CYC_TWO;
		end else if (is_br && cond) begin
			cyc = CYC_TWO;
		end
		// The count is kept as N-1 so that ready_out is low for the cycles still owed.
		busy_d = (busy_q == 3'h0) ? 3'h0 : busy_q - 3'h1;
		if (ready_out && issue_in) begin
			busy_d = cyc - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hold-off: a request offered while ready_out is low is ignored, so the core
	// must keep offering it; this keeps the listed cycle counts exact.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			busy_q    <= 3'h0;
			ready_out <= 1'b0;
		end else begin
			busy_q    <= busy_d;
			ready_out <= (busy_d == 3'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Results: one-cycle pulses registered from the operands seen at the taking edge.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			flags_we_out <= 1'b0;
			flags_out    <= 8'h00;
			pair_wr_out  <= '0;
			flow_out     <= '0;
		end else begin
			flags_we_out <= 1'b0;
			pair_wr_out  <= '0;
			flow_out     <= '0;
			if (ready_out && issue_in) begin
				flags_out <= flags_in;
				if (is_mul) begin
					pair_wr_out <= '{we: 1'b1, data: prod};
					flags_we_out <= 1'b1;
					flags_out[FL_C] <= prod_c;
					flags_out[FL_Z] <= prod == 16'h0000;
				end else if (is_cmp) begin
					flags_we_out <= 1'b1;
					flags_out[FL_C] <= diff[8];
					// Compare with carry only keeps Z set, so multi-byte compares chain.
					flags_out[FL_Z] <= (diff[7:0] == 8'h00)
						& (!hit(instr_in, M_TWO, P_CPC) | flags_in[FL_Z]);
					flags_out[FL_N] <= diff[7];
					flags_out[FL_V] <= (rd_val_in[7] ^ cmp_b[7]) & (rd_val_in[7] ^ diff[7]);
					flags_out[FL_S] <= diff[7]
						^ ((rd_val_in[7] ^ cmp_b[7]) & (rd_val_in[7] ^ diff[7]));
					flags_out[FL_H] <= (!rd_val_in[3] & cmp_b[3]) | (cmp_b[3] & diff[3])
						| (diff[3] & !rd_val_in[3]);
				end else if (hit(instr_in, M_REL, P_RJ) | hit(instr_in, M_REL, P_RC)) begin
					flow_out.pc_load <= 1'b1;
					flow_out.pc_next <= pc_in + rel12 + PC_ONE;
					flow_out.push <= hit(instr_in, M_REL, P_RC);
					flow_out.push_data <= pc_in + PC_ONE;
				end else if (hit(instr_in, M_FULL, P_IJ) | hit(instr_in, M_FULL, P_IC)) begin
					flow_out.pc_load <= 1'b1;
					flow_out.pc_next <= z_ptr_in;
					flow_out.push <= hit(instr_in, M_FULL, P_IC);
					flow_out.push_data <= pc_in + PC_ONE;
				end else if (hit(instr_in, M_LONG, P_JMP) | hit(instr_in, M_LONG, P_CALL)) begin
					flow_out.pc_load <= 1'b1;
					flow_out.pc_next <= instr_word2_in;
					flow_out.push <= hit(instr_in, M_LONG, P_CALL);
					flow_out.push_data <= pc_in + PC_TWO;
				end else if (hit(instr_in, M_FULL, P_RET) | hit(instr_in, M_FULL, P_INTERRUPT_EXIT)) begin
					flow_out.pc_load <= 1'b1;
					flow_out.pc_next <= stack_top_in;
					flow_out.pop <= 1'b1;
					// Interrupt exit keeps every other flag as it came in.
					if (hit(instr_in, M_FULL, P_INTERRUPT_EXIT)) begin
						flags_we_out <= 1'b1;
						flags_out[FL_I] <= 1'b1;
					end
				end else if (is_skip) begin
					// The follower's length sets the distance, so the core must decode it.
					if (cond) begin
						flow_out.pc_load <= 1'b1;
						flow_out.pc_next <= pc_in + (next_is_long_in ? PC_THREE : PC_TWO);
					end
				end else if (is_br && cond) begin
					flow_out.pc_load <= 1'b1;
					flow_out.pc_next <= pc_in + rel7 + PC_ONE;
				end
			end
		end
	end
endmodule // mbs_exec
`default_nettype wire

// *** hw/mbs_multiplier.sv ***
// Purpose: 8x8 multiplier with signed, unsigned, mixed and fractional forms.
// Assumes: Operands stay stable while the result is used.
// Notes:   Pure combinational; the two-cycle timing lives in the executor.
`timescale 1ns/1ps
`default_nettype none
module mbs_multiplier
	import mbs_pkg::*;
(
	input  wire logic [7:0]  a_in,
	input  wire logic [7:0]  b_in,
	input  wire logic        a_signed_in,
	input  wire logic        b_signed_in,
	input  wire logic        frac_in,
	output logic      [15:0] prod_out,
	output logic             carry_out
);
	logic signed [17:0] raw;
	logic        [15:0] full;

	always_comb begin
		raw  = $signed({a_signed_in & a_in[7], a_in}) * $signed({b_signed_in & b_in[7], b_in});
		full = raw[15:0];
		// Carry is the product's top bit before the fractional shift.
		carry_out = full[15];
		prod_out  = frac_in ? {full[14:0], 1'b0} : full;
	end
endmodule // mbs_multiplier
`default_nettype wire

// *** hw/mbs_pkg.sv ***
// Purpose: Shared constants and types for the multiply, branch and skip execution block.
// Assumes: One core clock; instruction words arrive already fetched from program memory.
// Notes:   Opcode patterns follow the usual 16-bit encoding of this 8-bit core family.
// Notes on behaviour
// - Integer multiplies write full 16-bit product to pair, update Z and C, 2 cycles.
// - Fractional multiplies shift product left one, update Z and C, 2 cycles.
// - Relative jump PC+k+1 2 cycles, indirect from Z 2, direct 3; no flags.
// - Relative/indirect entry 3 cycles, direct 4; exits pop PC in 4 cycles.
// - Interrupt exit sets global interrupt enable; no other flag change in group.
// - Compare-skip-equal skips next one- or two-word instruction, 1/2/3 cycles.
// - Compares compute Rd-Rr, Rd-Rr-C, Rd-K; set Z,N,V,C,H; 1 cycle.
// - Register bit skips test bit b, skip next instruction, 1/2/3 cycles.
// - I/O bit skips test bit b of I/O register, same skip timing.
// - Generic branches test flag s set or clear (N xor V in place of S when s is 4), PC+k+1, 1 or 2 cycles.
// - Named branches test Z, C or N directly, PC+k+1, 1 or 2 cycles.
// - Signed branches test N xor V; ge on 0, lt on 1.
// - Half-carry, transfer and overflow branches test H, T, V; 1 or 2 cycles.
package mbs_pkg;
	localparam int unsigned PC_W = 16;
	localparam int unsigned STK_W = 16;
	// Status flag bit positions.
	localparam int unsigned FL_C = 0;
	localparam int unsigned FL_Z = 1;
	localparam int unsigned FL_N = 2;
	localparam int unsigned FL_V = 3;
	localparam int unsigned FL_S = 4;
	localparam int unsigned FL_H = 5;
	localparam int unsigned FL_T = 6;
	localparam int unsigned FL_I = 7;
	// Cycle counts.
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	localparam logic [15:0] PC_ONE = 16'h0001;
	localparam logic [15:0] PC_TWO = 16'h0002;
	localparam logic [15:0] PC_THREE = 16'h0003;
	localparam logic [15:0] SKIP_NONE = 16'h0001;
	// Opcode masks and patterns.
	localparam logic [15:0] M_MUL = 16'hfc00;
	localparam logic [15:0] P_MUL = 16'h9c00;
	localparam logic [15:0] M_SIGNED_PRODUCT_OP = 16'hff00;
	localparam logic [15:0] P_SIGNED_PRODUCT_OP = 16'h0200;
	localparam logic [15:0] M_MSU = 16'hff88;
	localparam logic [15:0] P_MSU = 16'h0300;
	localparam logic [15:0] P_FRACTIONAL_UNSIGNED_PRODUCT = 16'h0308;
	localparam logic [15:0] P_FRACTIONAL_SIGNED_PRODUCT = 16'h0380;
	localparam logic [15:0] P_FMSU = 16'h0388;
	localparam logic [15:0] M_REL = 16'hf000;
	localparam logic [15:0] P_RJ = 16'hc000;
	localparam logic [15:0] P_RC = 16'hd000;
	localparam logic [15:0] P_CPI = 16'h3000;
	localparam logic [15:0] M_FULL = 16'hffff;
	localparam logic [15:0] P_IJ = 16'h9409;
	localparam logic [15:0] P_IC = 16'h9509;
	localparam logic [15:0] P_RET = 16'h9508;
	localparam logic [15:0] P_INTERRUPT_EXIT = 16'h9518;
	localparam logic [15:0] M_LONG = 16'hfe0e;
	localparam logic [15:0] P_JMP = 16'h940c;
	localparam logic [15:0] P_CALL = 16'h940e;
	localparam logic [15:0] M_LDS = 16'hfc0f;
	localparam logic [15:0] P_LDS = 16'h9000;
	localparam logic [15:0] M_TWO = 16'hfc00;
	localparam logic [15:0] P_COMPARE_SKIP_EQUAL = 16'h1000;
	localparam logic [15:0] P_CP = 16'h1400;
	localparam logic [15:0] P_CPC = 16'h0400;
	localparam logic [15:0] M_SKB = 16'hfe08;
	localparam logic [15:0] P_SKIP_REG_BIT_CLEAR = 16'hfc00;
	localparam logic [15:0] P_SKIP_REG_BIT_SET = 16'hfe00;
	localparam logic [15:0] M_IOB = 16'hff00;
	localparam logic [15:0] P_SKIP_IO_BIT_CLEAR = 16'h9900;
	localparam logic [15:0] P_SKIP_IO_BIT_SET = 16'h9b00;
	localparam logic [15:0] M_BR = 16'hf800;
	localparam logic [15:0] P_BRS = 16'hf000;
	localparam logic [15:0] P_BRC = 16'hf400;

	typedef enum logic [1:0] {MBS_MUL_INT, MBS_MUL_FRAC} mbs_mul_kind_t;

	// Register file write request for the product register pair.
	typedef struct packed {
		logic        we;
		logic [15:0] data;
	} mbs_pair_wr_t;

	// Program counter and stack request.
	typedef struct packed {
		logic             pc_load;
		logic [PC_W-1:0]  pc_next;
		logic             push;
		logic [STK_W-1:0] push_data;
		logic             pop;
	} mbs_flow_t;
endpackage : mbs_pkg
